// >>> design/cl_consts.svh
// Register offsets, field positions, reset values and timing figures of the loader status block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CL_CONSTS_SVH
`define CL_CONSTS_SVH

// ---------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------
`define CL_OFF_ROM_ADDR 8'h00
`define CL_OFF_ROM_EV 8'h04
`define CL_OFF_TALLY 8'h08
`define CL_OFF_PUMP_LIM 8'h0c
`define CL_OFF_FUSE_EV 8'h10
`define CL_OFF_CTRL 8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CL_ROM_NO_ACK 3
`define CL_ROM_EMPTY 2
`define CL_ROM_FAIL 1
`define CL_ROM_CRC 0
`define CL_FUSE_MANUAL 7
`define CL_FUSE_STATUS 6
`define CL_FUSE_PUMP 5
`define CL_FUSE_PROG_FAIL 3
`define CL_FUSE_EMPTY 2
`define CL_FUSE_FAIL 1
`define CL_FUSE_CRC 0
`define CL_FUSE_EV_MASK 8'hef
`define CL_CTRL_ALLOW 0
`define CL_CTRL_GATE 1
`define CL_CTRL_SRESET 2
`define CL_CTRL_GO 3
`define CL_CTRL_RETRY_LO 4
`define CL_CTRL_BUSY 8

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define CL_RST_ROM_ADDR 7'h50
`define CL_RST_PUMP_LIM 14'h3d0
`define CL_RST_RETRY 4'h4
`define CL_TALLY_MAX 4'hf
`define CL_PUMP_UNIT_US 1024
`define CL_CLK_KHZ 40000

`endif

// >>> design/cl_pkg.sv
// Types shared by the loader status block and its surroundings.
// Assumes cl_consts.svh is on the include path.
package cl_pkg;
  `include "cl_consts.svh"

  typedef enum logic [1:0] {
    CL_IDLE,
    CL_ISSUE,
    CL_WAIT
  } cl_seq_e;

  // Result of one load attempt, valid with load_done
  typedef struct packed {
    logic no_ack;
    logic crc;
    logic fail;
    logic empty;
  } cl_load_res_s;

  typedef struct packed {
    logic [6:0] dev_addr;
    logic [3:0] rom_ev;
    logic [3:0] tally;
    logic [13:0] pump_lim;
    logic [7:0] fuse_ev;
    logic allow;
    logic gate;
    logic sreset;
    logic [3:0] retry_lim;
    logic go;
    cl_seq_e st;
    logic [1:0] step;
    logic [3:0] tries;
    logic req;
    logic busy;
    logic [2:0] st_sync;
    logic [2:0] pump_sync;
    logic st_f;
    logic pump_f;
    logic [15:0] tick;
    logic [14:0] units;
    logic waitreq;
    logic [31:0] rdata;
  } cl_state_s;
endpackage : cl_pkg

// >>> design/cl_loader_status.sv
// Loader status block: Avalon-MM register slave, load sequencer, event flags and pump monitor.
// Assumes a loader engine on sys_clk that answers each load_req with one load_done pulse,
// and fuse macro status and pump sense arriving asynchronously on pins.
`timescale 1ns/1ps
`include "cl_consts.svh"

// Notes on behaviour
// - EEPROM bus device address is a 7-bit field resetting to 0x50.
// - No acknowledge sets sticky flag bit 3, not the failure flag; write 1 clears.
// - With load allow off no EEPROM read happens, so no-ack never sets.
// - EEPROM load of empty configuration sets sticky bit 2; write 1 clears.
// - EEPROM load failure sets sticky bit 1, never for no response; write 1 clears.
// - EEPROM CRC errors set sticky bit 0; write 1 clears.
// - 4-bit CRC tally counts each EEPROM CRC error not coinciding with a tally write, saturating at 0xF.
// - Writing zero clears the tally; other values preset it.
// - Tally writes act only when loader is neither gated nor soft reset.
// - 14-bit pump limit in 1024 us units, resetting to 0x3D0.
// - Pump enabled longer than limit sets fuse flag bit 5.
// - Write 1 clears pump flag only after pump sense has deasserted.
// - Bit 6 latches high fuse status; clear re-sets while status stays high.
// - Completion of a manual fuse request sets sticky bit 7; write 1 clears.
// - Program-assist failure sets sticky bit 3; write 1 clears.
// - Fuse load of empty configuration sets sticky bit 2; write 1 clears.
// - Fuse load failure sets sticky bit 1; write 1 clears.
// - Fuse load CRC errors set sticky bit 0; write 1 clears.
// - EEPROM loads with no ack or CRC error are attempted up to the retry limit in total, once for a limit of zero, before failure is flagged.
// - Load order: fuse common, EEPROM common, fuse user, EEPROM user.
module cl_loader_status #(
  parameter int PUMP_UNIT_CYCLES = `CL_PUMP_UNIT_US * `CL_CLK_KHZ / 1000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Loader engine link
  output logic load_req,
  output logic [1:0] load_section,
  output logic [6:0] rom_dev_addr,
  output logic loader_busy,
  output logic loader_gate,
  output logic loader_soft_reset,
  input wire logic load_done,
  input wire cl_pkg::cl_load_res_s load_result,
  // Fuse macro events
  input wire logic manual_done,
  input wire logic prog_help_fail,
  input wire logic fuse_status_pin,
  input wire logic pump_sense_pin
);
  import cl_pkg::*;

  localparam logic [15:0] UNIT_LAST = 16'(PUMP_UNIT_CYCLES - 1);

  cl_state_s q;
  cl_state_s d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction : merge

  function automatic logic is_rom_step(input logic [1:0] step);
    is_rom_step = step[0];
  endfunction : is_rom_step

  // The two low address bits never select a register
  function automatic logic [7:0] reg_index(input logic [7:0] addr);
    reg_index = addr & 8'hfc;
  endfunction : reg_index

  // Go is a strobe, so it always reads back as zero
  function automatic logic [31:0] ctrl_word(input cl_state_s s);
    ctrl_word = {23'h0, s.busy, s.retry_lim, 1'b0, s.sreset, s.gate, s.allow};
  endfunction : ctrl_word

  // Reserved and unmapped bits always read as zero
  function automatic logic [31:0] read_word(input cl_state_s s, input logic [7:0] addr);
    case (reg_index(addr))
      `CL_OFF_ROM_ADDR: begin
        read_word = {25'h0, s.dev_addr};
      end
      `CL_OFF_ROM_EV: begin
        read_word = {28'h0, s.rom_ev};
      end
      `CL_OFF_TALLY: begin
        read_word = {28'h0, s.tally};
      end
      `CL_OFF_PUMP_LIM: begin
        read_word = {18'h0, s.pump_lim};
      end
      `CL_OFF_FUSE_EV: begin
        read_word = {24'h0, s.fuse_ev & `CL_FUSE_EV_MASK};
      end
      `CL_OFF_CTRL: begin
        read_word = ctrl_word(s);
      end
      default: begin
        read_word = 32'h0;
      end
    endcase
  endfunction : read_word

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin : next_state
    logic wr_hit;
    logic [31:0] wm;
    logic [31:0] cur;
    logic [3:0] rom_set;
    logic [3:0] rom_clr;
    logic [7:0] fuse_set;
    logic [7:0] fuse_clr;
    logic tally_inc;
    logic tally_wr;
    logic [3:0] tally_wv;
    logic [3:0] lim_eff;
    logic advance;
    wr_hit = 1'b0;
    wm = 32'h0;
    cur = 32'h0;
    rom_set = 4'h0;
    rom_clr = 4'h0;
    fuse_set = 8'h0;
    fuse_clr = 8'h0;
    tally_inc = 1'b0;
    tally_wr = 1'b0;
    tally_wv = 4'h0;
    advance = 1'b0;
    lim_eff = (q.retry_lim == 4'h0) ? 4'h1 : q.retry_lim;
    d = q;
    d.req = 1'b0;

    // Pin inputs: first stage feeds only the second
    d.st_sync = {q.st_sync[1:0], fuse_status_pin};
    d.pump_sync = {q.pump_sync[1:0], pump_sense_pin};
    if (q.st_sync[1] == q.st_sync[2]) begin
      d.st_f = q.st_sync[2];
    end
    if (q.pump_sync[1] == q.pump_sync[2]) begin
      d.pump_f = q.pump_sync[2];
    end

    // -------------------------------------------------------------
    // Register bus: waitrequest drops one cycle, commit at that edge
    // -------------------------------------------------------------
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata = read_word(q, avs_address);
    end
    wr_hit = avs_write && !q.waitreq;
    wm = avs_writedata & lane_mask(avs_byteenable);
    if (wr_hit) begin
      case (reg_index(avs_address))
        `CL_OFF_ROM_ADDR: begin
          cur = merge({25'h0, q.dev_addr}, avs_writedata, avs_byteenable);
          d.dev_addr = cur[6:0];
        end
        `CL_OFF_ROM_EV: rom_clr = wm[3:0];
        `CL_OFF_TALLY: begin
          tally_wr = avs_byteenable[0] && !q.gate && !q.sreset;
          tally_wv = avs_writedata[3:0];
        end
        `CL_OFF_PUMP_LIM: begin
          cur = merge({18'h0, q.pump_lim}, avs_writedata, avs_byteenable);
          d.pump_lim = cur[13:0];
        end
        `CL_OFF_FUSE_EV: begin
          fuse_clr = wm[7:0] & `CL_FUSE_EV_MASK;
          fuse_clr[`CL_FUSE_PUMP] = wm[`CL_FUSE_PUMP] && !q.pump_f;
        end
        `CL_OFF_CTRL: begin
          cur = merge(ctrl_word(q), avs_writedata, avs_byteenable);
          d.allow = cur[`CL_CTRL_ALLOW];
          d.gate = cur[`CL_CTRL_GATE];
          d.sreset = cur[`CL_CTRL_SRESET];
          d.retry_lim = cur[`CL_CTRL_RETRY_LO +: 4];
          if (wm[`CL_CTRL_GO]) begin
            d.go = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // -------------------------------------------------------------
    // Load sequencer
    // -------------------------------------------------------------
    // Gating freezes the sequence; soft reset abandons it without losing flags
    if (q.sreset) begin
      d.st = CL_IDLE;
      d.go = 1'b0;
    end else if (!q.gate) begin
      case (q.st)
        CL_IDLE: begin
          if (q.go) begin
            d.go = 1'b0;
            d.step = 2'd0;
            d.tries = 4'h0;
            d.st = CL_ISSUE;
          end
        end
        CL_ISSUE: begin
          if (is_rom_step(q.step) && !q.allow) begin
            advance = 1'b1;
          end else begin
            d.req = 1'b1;
            d.st = CL_WAIT;
          end
        end
        CL_WAIT: begin
          if (load_done) begin
            if (is_rom_step(q.step)) begin
              rom_set[`CL_ROM_CRC] = load_result.crc;
              rom_set[`CL_ROM_EMPTY] = load_result.empty;
              tally_inc = load_result.crc;
              if ((load_result.no_ack || load_result.crc) && (q.tries + 4'h1 < lim_eff)) begin
                d.tries = q.tries + 4'h1;
                d.st = CL_ISSUE;
              end else begin
                rom_set[`CL_ROM_NO_ACK] = load_result.no_ack;
                rom_set[`CL_ROM_FAIL] = !load_result.no_ack &&
                                        (load_result.crc || load_result.fail);
                advance = 1'b1;
              end
            end else begin
              fuse_set[`CL_FUSE_CRC] = load_result.crc;
              fuse_set[`CL_FUSE_EMPTY] = load_result.empty;
              fuse_set[`CL_FUSE_FAIL] = load_result.fail;
              advance = 1'b1;
            end
          end
        end
        default: d.st = CL_IDLE;
      endcase
    end
    if (advance) begin
      d.tries = 4'h0;
      if (q.step == 2'd3) begin
        d.st = CL_IDLE;
      end else begin
        d.step = q.step + 2'd1;
        d.st = CL_ISSUE;
      end
    end
    d.busy = (d.st != CL_IDLE);

    // -------------------------------------------------------------
    // Pump monitor: counts whole units while the pump stays on
    // -------------------------------------------------------------
    if (!q.pump_f) begin
      d.tick = 16'h0;
      d.units = 15'h0;
    end else if (q.tick >= UNIT_LAST) begin
      d.tick = 16'h0;
      if (q.units != 15'h7fff) begin
        d.units = q.units + 15'h1;
      end
    end else begin
      d.tick = q.tick + 16'h1;
    end
    fuse_set[`CL_FUSE_PUMP] = q.pump_f && (q.units > {1'b0, q.pump_lim});
    fuse_set[`CL_FUSE_STATUS] = q.st_f;
    fuse_set[`CL_FUSE_MANUAL] = manual_done;
    fuse_set[`CL_FUSE_PROG_FAIL] = prog_help_fail;

    // Set wins over a clear arriving in the same cycle
    d.rom_ev = (q.rom_ev & ~rom_clr) | rom_set;
    d.fuse_ev = ((q.fuse_ev & ~fuse_clr) | fuse_set) & `CL_FUSE_EV_MASK;
    if (tally_wr) begin
      d.tally = tally_wv;
    end else if (tally_inc && q.tally != `CL_TALLY_MAX) begin
      d.tally = q.tally + 4'h1;
    end

    if (!rst_n) begin
      d = '0;
      d.dev_addr = `CL_RST_ROM_ADDR;
      d.pump_lim = `CL_RST_PUMP_LIM;
      d.retry_lim = `CL_RST_RETRY;
      d.go = 1'b1;
      d.st = CL_IDLE;
      d.waitreq = 1'b1;
    end
  end : next_state

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from state
  // ---------------------------------------------------------------
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign load_req = q.req;
  assign load_section = q.step;
  assign rom_dev_addr = q.dev_addr;
  assign loader_busy = q.busy;
  assign loader_gate = q.gate;
  assign loader_soft_reset = q.sreset;
endmodule : cl_loader_status

// >>> verification/cl_status_monitor.sv
// Checker of the loader status block: bus handshake, loader link, reserved bits.
// Assumes binding to cl_loader_status.
`timescale 1ns/1ps
module cl_status_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Loader link
  input wire logic load_req,
  input wire logic [1:0] load_section,
  input wire logic [6:0] rom_dev_addr,
  input wire logic loader_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_ok;
  logic [5:0] wa;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wa = avs_address[7:2];
  // ----------
  // Properties
  // ----------
  wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  answer_due_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  addr_reset_a: assert property ($rose(rst_n) |-> rom_dev_addr == 7'h50)
    else $error("device address reset wrong");
  boot_first_a: assert property ($rose(loader_busy) |-> ##[1:3] (load_req && load_section == 2'h0))
    else $error("first section not fuse common");
  req_pulse_a: assert property (load_req |=> !load_req && loader_busy)
    else $error("load request not a pulse");
  rsv_rom_a: assert property (rd_ok && (wa == 6'h1 || wa == 6'h2) |-> avs_readdata[31:4] == 28'h0)
    else $error("rom reserved bits set");
  rsv_addr_a: assert property (rd_ok && wa == 6'h0 |-> avs_readdata[31:7] == 25'h0)
    else $error("address reserved bits set");
  rsv_fuse_a: assert property (rd_ok && wa == 6'h4 |-> avs_readdata[31:8] == 24'h0 && !avs_readdata[4])
    else $error("fuse reserved bits set");
  rsv_pump_a: assert property (rd_ok && wa == 6'h3 |-> avs_readdata[31:14] == 18'h0)
    else $error("limit reserved bits set");
  cover property (load_req && load_section == 2'h3);
  cover property (avs_write && !avs_waitrequest);
  cover property (rd_ok && wa == 6'h4);
endmodule : cl_status_monitor

bind cl_loader_status cl_status_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .load_req(load_req),
  .load_section(load_section), .rom_dev_addr(rom_dev_addr), .loader_busy(loader_busy));

// >>> verification/cl_engine_model.sv
// Loader engine stand-in: one done pulse and result per load request.
// Assumes the status block's link on the same clock.
`timescale 1ns/1ps
module cl_engine_model
  import cl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  input wire logic load_req,
  input wire logic [1:0] load_section,
  output logic load_done,
  output cl_pkg::cl_load_res_s load_result,
  // Results chosen by the bench
  input wire logic [3:0] rom_res,
  input wire logic [3:0] fuse_res
);
  int cnt;
  logic slow;
  logic rom;
  // Quick and slow answers alternate; result lines toggle outside the pulse
  always @(posedge sys_clk) begin
    load_done <= 1'b0;
    load_result <= ~load_result;
    if (!rst_n) begin
      cnt <= 0;
      slow <= 1'b0;
      load_result <= '0;
    end else if (load_req) begin
      cnt <= slow ? 9 : 1;
      slow <= ~slow;
      rom <= load_section[0];
    end else if (cnt == 1) begin
      load_done <= 1'b1;
      load_result <= cl_load_res_s'(rom ? rom_res : fuse_res);
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : cl_engine_model

// >>> verification/tb.sv
// Bench of the loader status block: Avalon-MM register tasks and loader scenarios.
// Assumes the package, design, checker and engine stand-in are compiled first.
`timescale 1ns/1ps
module tb;
  import cl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic avs_waitrequest, load_req, loader_busy, load_done;
  logic loader_gate, loader_soft_reset;
  logic manual_done = 1'b0;
  logic prog_help_fail = 1'b0;
  logic fuse_status_pin = 1'b0;
  logic pump_sense_pin = 1'b0;
  logic [1:0] load_section;
  logic [6:0] rom_dev_addr;
  logic [3:0] rom_res = 4'h4;
  logic [3:0] fuse_res = 4'h7;
  cl_load_res_s load_result;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  cl_loader_status #(.PUMP_UNIT_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .load_req(load_req), .load_section(load_section),
    .rom_dev_addr(rom_dev_addr), .loader_busy(loader_busy), .loader_gate(loader_gate),
    .loader_soft_reset(loader_soft_reset), .load_done(load_done), .load_result(load_result),
    .manual_done(manual_done), .prog_help_fail(prog_help_fail),
    .fuse_status_pin(fuse_status_pin), .pump_sense_pin(pump_sense_pin));
  cl_engine_model ENG (.sys_clk(sys_clk), .rst_n(rst_n), .load_req(load_req),
    .load_section(load_section), .load_done(load_done), .load_result(load_result),
    .rom_res(rom_res), .fuse_res(fuse_res));
  // ----------
  // Tasks
  // ----------
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    n_checks++;
    if (avs_readdata !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, avs_readdata, e);
    end
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic run(input logic [31:0] c);
    wr(8'h14, c);
    while (loader_busy !== 1'b1) @(posedge sys_clk);
    while (loader_busy !== 1'b0) @(posedge sys_clk);
  endtask : run
  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    while (loader_busy !== 1'b0) @(posedge sys_clk);
    rd(8'h00, 32'h50);
    rd(8'h0c, 32'h3d0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h7);
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h0);
    fuse_res <= 4'h0;
    run(32'h29);
    rd(8'h04, 32'h3);
    rd(8'h08, 32'h4);
    rd(8'h14, 32'h21);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h2);
    wr(8'h04, 32'hff);
    rom_res <= 4'h9;
    run(32'h19);
    rd(8'h04, 32'hc);
    rom_res <= 4'h4;
    wr(8'h08, 32'he);
    run(32'h29);
    rd(8'h08, 32'hf);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(8'h14, 32'h2 << i);
      chk({30'h0, loader_soft_reset, loader_gate}, 32'h1 << i);
      wr(8'h08, 32'h5);
      wr(8'h14, 32'h0);
      rd(8'h08, 32'h0);
    end
    wr(8'h00, 32'hff);
    rd(8'h00, 32'h7f);
    chk({25'h0, rom_dev_addr}, 32'h7f);
    rd(8'h20, 32'h0);
    wr(8'h0c, 32'h2);
    pump_sense_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(8'h10, 32'h0);
    repeat (40) @(posedge sys_clk);
    rd(8'h10, 32'h20);
    // Raise the limit so only the sense guard can keep the flag against the clear
    wr(8'h0c, 32'h3fff);
    wr(8'h10, 32'h20);
    rd(8'h10, 32'h20);
    pump_sense_pin <= 1'b0;
    fuse_status_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wr(8'h10, 32'h60);
    rd(8'h10, 32'h40);
    fuse_status_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    wr(8'h10, 32'h40);
    rd(8'h10, 32'h0);
    manual_done <= 1'b1;
    @(posedge sys_clk);
    manual_done <= 1'b0;
    prog_help_fail <= 1'b1;
    @(posedge sys_clk);
    prog_help_fail <= 1'b0;
    rd(8'h10, 32'h88);
    wr(8'h10, 32'h88);
    rd(8'h10, 32'h0);
    complete_run();
  end
endmodule : tb
